// ==== src/cst_pkg.sv ====
// Shared constants and types for the consist and speed-trim command block.
package cst_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration locations, as seen by programming commands.
  localparam int CST_CV_AW = 10;
  localparam logic [9:0] CST_CV_BASE_ACCEL = 10'h003;
  localparam logic [9:0] CST_CV_BASE_BRAKE = 10'h004;
  localparam logic [9:0] CST_CV_CONSIST_ADDR = 10'h013;
  localparam logic [9:0] CST_CV_GATE_LOW = 10'h015;
  localparam logic [9:0] CST_CV_GATE_HIGH = 10'h016;
  localparam logic [9:0] CST_CV_ACCEL_OFFSET = 10'h017;
  localparam logic [9:0] CST_CV_BRAKE_OFFSET = 10'h018;
  localparam logic [9:0] CST_CV_TABLE_SELECT = 10'h019;
  localparam logic [9:0] CST_CV_CONFIG = 10'h01d;
  localparam logic [9:0] CST_CV_FWD_TRIM = 10'h042;
  localparam logic [9:0] CST_CV_TABLE_FIRST = 10'h043;
  localparam logic [9:0] CST_CV_TABLE_LAST = 10'h05e;
  localparam logic [9:0] CST_CV_REV_TRIM = 10'h05f;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions and encodings.
  localparam int CST_TAB_POINTS = 28;
  localparam int CST_CFG_TABLE_EN_BIT = 4;
  localparam int CST_REV_FACING_BIT = 7;
  localparam int CST_SIGN_BIT = 7;
  localparam int CST_GHI_LIGHT_FWD = 0;
  localparam int CST_GHI_LIGHT_REV = 1;
  localparam logic [7:0] CST_TAB_SEL_USER = 8'h10;
  localparam logic [7:0] CST_RATE_MAX = 8'hff;
  localparam int CST_TRIM_SHIFT = 7;
  localparam int CST_SPAN_NUM = 27;
  localparam int CST_SPAN_DEN = 125;
  localparam logic [6:0] CST_STEP_MAX_28 = 7'h1c;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values.
  localparam logic [7:0] CST_TRIM_RESET = 8'h80;
  localparam logic [7:0] CST_ZERO_RESET = 8'h00;

  typedef enum logic [1:0] {
    CST_PKT_IDLE,
    CST_PKT_SPEED,
    CST_PKT_FUNC,
    CST_PKT_PROG
  } cst_kind_t;

endpackage

// ==== src/cst_rate_sat.sv ====
// Consist rate adjustment: baseline plus sign-magnitude offset, saturated.
`timescale 1ns/10ps
module cst_rate_sat (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic consist_on,
  input wire logic [7:0] base,
  input wire logic [7:0] offset,
  output logic [7:0] rate_reg
);
  import cst_pkg::*;

  logic [6:0] mag;
  logic neg;
  logic [8:0] sum_up;
  logic [7:0] sum_clip;
  logic [7:0] rate_next;

  // A magnitude of zero with the sign set is plain zero, so no special case.
  assign mag = offset[6:0]; // R11
  assign neg = offset[CST_SIGN_BIT]; // R11
  assign sum_up = {1'b0, base} + {2'b00, mag};
  // Positive offset lengthens the rate (slower), negative shortens it.
  assign sum_clip = neg ? ((base < {1'b0, mag}) ? 8'h00 : base - {1'b0, mag})
                        : (sum_up[8] ? CST_RATE_MAX : sum_up[7:0]); // R10 R12
  assign rate_next = consist_on ? sum_clip : base; // R9 R13

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rate_reg <= 8'h00;
    end else begin
      rate_reg <= rate_next;
    end
  end

endmodule // cst_rate_sat

// ==== src/cst_top.sv ====
// Consist recognition, function gating, rate offsets and trimmed speed table.
`timescale 1ns/10ps

// Functional notes
// [R1] Low seven bits consist address; bit seven reverses
// [R2] Zero consist address disables all consist behaviour
// [R3] Primary address speed ignored while consist active
// [R4] Programming on consist address is ignored
// [R5] Low gate bits enable F1 to F8
// [R6] High gate bit zero enables forward light key
// [R7] High gate: weight 2 reverse light, 16 F11
// [R8] Gates only affect consist address commands
// [R9] Consist rate equals baseline plus signed offset
// [R10] Summed rate saturates between 0 and 255
// [R11] Offsets are sign-magnitude; 128 means zero
// [R12] Positive offset slows, negative quickens response
// [R13] Without consist, baseline rates pass unchanged
// [R14] Table point scaled by trim over 128
// [R15] Forward trim forward, reverse trim reverse
// [R16] Trim bypassed when speed table disabled
// [R17] Select 16 picks user table when enabled
// [R18] User table: 28 locations, step one first
// [R19] Point 0 to 255 maps motor voltage linearly
// [R20] 128-step mode interpolates between table points
// [R21] Trimmed value clamps at maximum, never wraps
// [R22] Reverse facing only flips consist direction
module cst_top (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic pkt_valid,
  input wire cst_pkg::cst_kind_t pkt_kind,
  input wire logic pkt_is_primary,
  input wire logic [6:0] pkt_addr,
  input wire logic pkt_dir,
  input wire logic [6:0] pkt_speed,
  input wire logic pkt_mode28,
  input wire logic [12:0] pkt_fn_mask,
  input wire logic [12:0] pkt_fn_value,
  input wire logic [cst_pkg::CST_CV_AW-1:0] pkt_cv_index,
  input wire logic [7:0] pkt_cv_data,
  input wire logic [cst_pkg::CST_CV_AW-1:0] cfg_rd_addr,
  output logic [7:0] cfg_rd_data_reg,
  output logic consist_active,
  output logic dir_reg,
  output logic [6:0] step_reg,
  output logic light_key_forward,
  output logic light_key_reverse,
  output logic [11:0] fn_state,
  output logic [7:0] accel_rate_reg,
  output logic [7:0] brake_rate_reg,
  output logic [7:0] motor_level_reg
);
  import cst_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration storage.
  logic [7:0] base_accel_reg;
  logic [7:0] base_brake_reg;
  logic [7:0] consist_address_reg;
  logic [7:0] consist_function_gate_low_reg;
  logic [7:0] consist_function_gate_high_reg;
  logic [7:0] consist_accel_offset_reg;
  logic [7:0] consist_brake_offset_reg;
  logic [7:0] speed_table_select_reg;
  logic [7:0] config_reg;
  logic [7:0] forward_speed_trim_reg;
  logic [7:0] reverse_speed_trim_reg;
  logic [7:0] table_reg [0:CST_TAB_POINTS-1];
  logic mode28_reg;
  logic [13:0] key_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Packet decode.
  wire on_primary = pkt_valid && pkt_is_primary;
  wire on_consist = pkt_valid && !pkt_is_primary && consist_active &&
                    (pkt_addr == consist_address_reg[6:0]); // R1
  wire prog_take = on_primary && (pkt_kind == CST_PKT_PROG); // R4
  wire speed_take = (pkt_kind == CST_PKT_SPEED) &&
                    (on_consist || (on_primary && !consist_active)); // R3
  wire fn_take = pkt_kind == CST_PKT_FUNC;
  wire dir_in = on_consist ? (pkt_dir ^ consist_address_reg[CST_REV_FACING_BIT]) : pkt_dir; // R1 R22
  wire [5:0] gate_hi = consist_function_gate_high_reg[5:0];
  wire [13:0] key_gate = {gate_hi[5:2], consist_function_gate_low_reg,
                          gate_hi[CST_GHI_LIGHT_REV], gate_hi[CST_GHI_LIGHT_FWD]}; // R5 R6 R7
  wire [13:0] key_allow = on_primary ? 14'h3fff : (on_consist ? key_gate : 14'h0000); // R8
  wire [13:0] cmd_mask = {pkt_fn_mask[12:1], pkt_fn_mask[0], pkt_fn_mask[0]};
  wire [13:0] cmd_value = {pkt_fn_value[12:1], pkt_fn_value[0], pkt_fn_value[0]};
  wire in_table = (pkt_cv_index >= CST_CV_TABLE_FIRST) && (pkt_cv_index <= CST_CV_TABLE_LAST);
  wire [9:0] tab_wr_idx = pkt_cv_index - CST_CV_TABLE_FIRST;
  wire rd_in_table = (cfg_rd_addr >= CST_CV_TABLE_FIRST) && (cfg_rd_addr <= CST_CV_TABLE_LAST);
  wire [9:0] tab_rd_idx = cfg_rd_addr - CST_CV_TABLE_FIRST;

  assign consist_active = consist_address_reg[6:0] != 7'h00; // R2
  assign light_key_forward = key_reg[0];
  assign light_key_reverse = key_reg[1];
  assign fn_state = key_reg[13:2];

  ////////////////////////////////////////////////////////////////////////////
  // Programming writes.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      base_accel_reg <= CST_ZERO_RESET;
      base_brake_reg <= CST_ZERO_RESET;
      consist_address_reg <= CST_ZERO_RESET;
      consist_function_gate_low_reg <= CST_ZERO_RESET;
      consist_function_gate_high_reg <= CST_ZERO_RESET;
      consist_accel_offset_reg <= CST_ZERO_RESET;
      consist_brake_offset_reg <= CST_ZERO_RESET;
      speed_table_select_reg <= CST_ZERO_RESET;
      config_reg <= CST_ZERO_RESET;
      forward_speed_trim_reg <= CST_TRIM_RESET;
      reverse_speed_trim_reg <= CST_TRIM_RESET;
    end else if (prog_take) begin // R4
      case (pkt_cv_index)
        CST_CV_BASE_ACCEL: base_accel_reg <= pkt_cv_data;
        CST_CV_BASE_BRAKE: base_brake_reg <= pkt_cv_data;
        CST_CV_CONSIST_ADDR: consist_address_reg <= pkt_cv_data;
        CST_CV_GATE_LOW: consist_function_gate_low_reg <= pkt_cv_data;
        CST_CV_GATE_HIGH: consist_function_gate_high_reg <= pkt_cv_data;
        CST_CV_ACCEL_OFFSET: consist_accel_offset_reg <= pkt_cv_data;
        CST_CV_BRAKE_OFFSET: consist_brake_offset_reg <= pkt_cv_data;
        CST_CV_TABLE_SELECT: speed_table_select_reg <= pkt_cv_data;
        CST_CV_CONFIG: config_reg <= pkt_cv_data;
        CST_CV_FWD_TRIM: forward_speed_trim_reg <= pkt_cv_data;
        CST_CV_REV_TRIM: reverse_speed_trim_reg <= pkt_cv_data;
        default: ;
      endcase
    end
  end

  // One location per speed step, step one at the lowest location.
  genvar gi;
  generate
    for (gi = 0; gi < CST_TAB_POINTS; gi++) begin : g_tab
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          table_reg[gi] <= CST_ZERO_RESET;
        end else if (prog_take && in_table && (tab_wr_idx == 10'(gi))) begin
          table_reg[gi] <= pkt_cv_data; // R18
        end
      end
    end
    // Key states: bit 0 forward light, bit 1 reverse light, bits 13:2 F1 to F12.
    for (gi = 0; gi < 14; gi++) begin : g_key
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          key_reg[gi] <= 1'b0;
        end else if (fn_take && cmd_mask[gi] && key_allow[gi]) begin
          key_reg[gi] <= cmd_value[gi]; // R5 R6 R8
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Register read port, one cycle latency; unmapped locations read zero.
  logic [7:0] rd_next;
  always_comb begin
    rd_next = 8'h00;
    if (rd_in_table) begin
      rd_next = table_reg[tab_rd_idx[4:0]];
    end else begin
      case (cfg_rd_addr)
        CST_CV_BASE_ACCEL: rd_next = base_accel_reg;
        CST_CV_BASE_BRAKE: rd_next = base_brake_reg;
        CST_CV_CONSIST_ADDR: rd_next = consist_address_reg;
        CST_CV_GATE_LOW: rd_next = consist_function_gate_low_reg;
        CST_CV_GATE_HIGH: rd_next = consist_function_gate_high_reg;
        CST_CV_ACCEL_OFFSET: rd_next = consist_accel_offset_reg;
        CST_CV_BRAKE_OFFSET: rd_next = consist_brake_offset_reg;
        CST_CV_TABLE_SELECT: rd_next = speed_table_select_reg;
        CST_CV_CONFIG: rd_next = config_reg;
        CST_CV_FWD_TRIM: rd_next = forward_speed_trim_reg;
        CST_CV_REV_TRIM: rd_next = reverse_speed_trim_reg;
        default: rd_next = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Speed and direction.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cfg_rd_data_reg <= 8'h00;
      dir_reg <= 1'b1;
      step_reg <= 7'h00;
      mode28_reg <= 1'b0;
    end else begin
      cfg_rd_data_reg <= rd_next;
      if (speed_take) begin // R3
        dir_reg <= dir_in; // R1
        step_reg <= pkt_speed;
        mode28_reg <= pkt_mode28;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Rate offsets, one instance per direction of travel effort.
  cst_rate_sat u_accel (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .consist_on(consist_active),
    .base(base_accel_reg),
    .offset(consist_accel_offset_reg),
    .rate_reg(accel_rate_reg)
  ); // R9 R13

  cst_rate_sat u_brake (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .consist_on(consist_active),
    .base(base_brake_reg),
    .offset(consist_brake_offset_reg),
    .rate_reg(brake_rate_reg)
  ); // R9 R13

  ////////////////////////////////////////////////////////////////////////////
  // Speed curve. Preset curves other than the user table are not held here,
  // so any other selection falls back to the straight line.
  function automatic logic [7:0] line_pt(input logic [4:0] q);
    logic [12:0] t;
    t = (13'(q) + 13'd1) * 13'(CST_RATE_MAX);
    return 8'(t / 13'(CST_TAB_POINTS));
  endfunction

  wire table_en = config_reg[CST_CFG_TABLE_EN_BIT]; // R16
  wire use_user = table_en && (speed_table_select_reg == CST_TAB_SEL_USER); // R17
  wire [6:0] step_m1 = step_reg - 7'd1;
  wire [6:0] step28 = (step_reg > CST_STEP_MAX_28) ? (CST_STEP_MAX_28 - 7'd1) : step_m1;
  wire [11:0] span_t = 12'(step_m1) * 12'(CST_SPAN_NUM);
  // Each point covers about four and a half 128-mode steps.
  wire [4:0] q128 = 5'(span_t / 12'(CST_SPAN_DEN)); // R20
  wire [6:0] r128 = 7'(span_t % 12'(CST_SPAN_DEN)); // R20
  wire [4:0] pt_q = mode28_reg ? step28[4:0] : q128;
  wire [6:0] pt_r = mode28_reg ? 7'h00 : r128;
  wire [4:0] pt_q1 = (pt_q == 5'(CST_TAB_POINTS - 1)) ? pt_q : pt_q + 5'd1;
  wire [7:0] pt_lo = use_user ? table_reg[pt_q] : line_pt(pt_q); // R18 R19
  wire [7:0] pt_hi = use_user ? table_reg[pt_q1] : line_pt(pt_q1);
  wire signed [9:0] pt_diff = $signed({2'b00, pt_hi}) - $signed({2'b00, pt_lo});
  // Both factors are widened first so the product cannot wrap inside a narrower self-sized multiply.
  wire signed [17:0] pt_prod = 18'(pt_diff) * 18'($signed({1'b0, pt_r}));
  wire signed [17:0] pt_step = pt_prod / 18'sd125;
  wire [9:0] v_interp = 10'({2'b00, pt_lo}) + pt_step[9:0]; // R20
  wire [7:0] v_untrim = v_interp[7:0];
  wire [7:0] trim_sel = dir_reg ? forward_speed_trim_reg : reverse_speed_trim_reg; // R15
  wire [15:0] v_prod = 16'(v_untrim) * 16'(trim_sel); // R14
  wire [8:0] v_scaled = v_prod[CST_TRIM_SHIFT +: 9];
  wire [7:0] v_trim = v_scaled[8] ? CST_RATE_MAX : v_scaled[7:0]; // R21
  wire [7:0] motor_next = (step_reg == 7'h00) ? 8'h00 : (table_en ? v_trim : v_untrim); // R16

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      motor_level_reg <= 8'h00;
    end else begin
      motor_level_reg <= motor_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  wire [8:0] brk_sum = {1'b0, base_brake_reg} + {2'b00, consist_brake_offset_reg[6:0]};

  sequence s_consist_speed;
    speed_take && on_consist;
  endsequence

  sequence s_idle_two;
    !consist_active ##1 !consist_active;
  endsequence

  a_prog_consist_ignored: assert property ( // R4
    (pkt_valid && !pkt_is_primary && pkt_kind == CST_PKT_PROG)
    |=> $stable(consist_address_reg) && $stable(forward_speed_trim_reg) && $stable(reverse_speed_trim_reg))
    else $error("consist address changed by a consist-address programming command");
  a_primary_speed_blocked: assert property ( // R3
    (consist_active && on_primary && pkt_kind == CST_PKT_SPEED && !on_consist)
    |=> $stable(step_reg) && $stable(dir_reg))
    else $error("primary address speed taken while consist active");
  a_reverse_facing: assert property ( // R1
    s_consist_speed |=> dir_reg == ($past(pkt_dir) ^ $past(consist_address_reg[7])))
    else $error("consist direction not adjusted for facing");
  a_gate_low_f2: assert property ( // R5
    (fn_take && on_consist && pkt_fn_mask[2] && !consist_function_gate_low_reg[1]) |=> $stable(fn_state[1]))
    else $error("gated function two changed on consist address");
  a_primary_fn_acts: assert property ( // R8
    (fn_take && on_primary && pkt_fn_mask[3]) |=> fn_state[2] == $past(pkt_fn_value[3]))
    else $error("primary function three ignored");
  a_light_gate_fwd: assert property ( // R6
    (fn_take && on_consist && pkt_fn_mask[0] && gate_hi[0]) |=> light_key_forward == $past(pkt_fn_value[0]))
    else $error("forward light key not taken on consist address");
  a_gate_high_f11: assert property ( // R7
    (fn_take && on_consist && pkt_fn_mask[11] && !gate_hi[4]) |=> $stable(fn_state[10]))
    else $error("gated function eleven changed on consist address");
  a_rate_idle: assert property ( // R13
    s_idle_two |-> accel_rate_reg == $past(base_accel_reg))
    else $error("accel rate differs from baseline without consist");
  a_rate_saturate: assert property ( // R10
    (consist_active && !consist_brake_offset_reg[7] && brk_sum[8]) |=> brake_rate_reg == 8'hff)
    else $error("brake rate not saturated at top");
  a_trim_unity: assert property ( // R14
    (table_en && trim_sel == 8'h80 && step_reg != 7'h00) |=> motor_level_reg == $past(v_untrim))
    else $error("unity trim altered the curve");
  a_trim_bypass: assert property ( // R16
    (!table_en && step_reg != 7'h00) |=> motor_level_reg == $past(v_untrim))
    else $error("trim applied with speed table disabled");
  a_stop_zero: assert property ( // R19
    (step_reg == 7'h00) |=> motor_level_reg == 8'h00)
    else $error("motor level not zero at stop");

endmodule // cst_top

// ==== testbench/cst_station.sv ====
// Command station model that hands decoded packets to the consist block.
`timescale 1ns/10ps
module cst_station (
  input wire logic clk_sys,
  output logic pkt_valid,
  output cst_pkg::cst_kind_t pkt_kind,
  output logic pkt_is_primary,
  output logic [6:0] pkt_addr,
  output logic pkt_dir,
  output logic [6:0] pkt_speed,
  output logic pkt_mode28,
  output logic [12:0] pkt_fn_mask,
  output logic [12:0] pkt_fn_value,
  output logic [9:0] pkt_cv_index,
  output logic [7:0] pkt_cv_data
);
  import cst_pkg::*;

  initial begin
    pkt_valid = 1'b0;
    pkt_kind = CST_PKT_IDLE;
    {pkt_is_primary, pkt_addr, pkt_dir, pkt_speed, pkt_mode28} = '0;
    {pkt_fn_mask, pkt_fn_value, pkt_cv_index, pkt_cv_data} = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One packet per call; the valid pulse lasts exactly one clock.
  task automatic send(input cst_kind_t kind, input logic [1:0] pd, input logic [6:0] addr,
                      input logic [6:0] speed, input logic m28, input logic [25:0] fn, input logic [17:0] cv);
    @(posedge clk_sys);
    #1;
    pkt_valid = 1'b1;
    pkt_kind = kind;
    {pkt_is_primary, pkt_dir} = pd;
    {pkt_addr, pkt_speed, pkt_mode28} = {addr, speed, m28};
    {pkt_fn_mask, pkt_fn_value} = fn;
    {pkt_cv_index, pkt_cv_data} = cv;
    @(posedge clk_sys);
    #1;
    pkt_valid = 1'b0;
    // Fields are dead once the pulse ends; flipping them exposes any late sampling.
    {pkt_addr, pkt_speed} = ~{pkt_addr, pkt_speed};
    {pkt_fn_value, pkt_cv_data} = ~{pkt_fn_value, pkt_cv_data};
    pkt_is_primary = ~pkt_is_primary;
  endtask

  task automatic prog(input logic prim, input logic [6:0] addr, input logic [9:0] idx, input logic [7:0] data);
    send(CST_PKT_PROG, {prim, 1'b1}, addr, 7'h00, 1'b0, 26'h0, {idx, data});
  endtask

  task automatic spd(input logic prim, input logic [6:0] addr, input logic dir, input logic [6:0] step,
                     input logic m28);
    send(CST_PKT_SPEED, {prim, dir}, addr, step, m28, 26'h0, 18'h0);
  endtask

  task automatic fn(input logic prim, input logic [6:0] addr, input logic [12:0] mask, input logic [12:0] val);
    send(CST_PKT_FUNC, {prim, 1'b1}, addr, 7'h00, 1'b0, {mask, val}, 18'h0);
  endtask
endmodule // cst_station

// ==== testbench/testbench.sv ====
// Self-checking bench for the consist and speed-trim block.
`timescale 1ns/10ps
module testbench;
  import cst_pkg::*;
  typedef struct packed {
    logic [7:0] base;
    logic [7:0] offset;
    logic [7:0] consist;
    logic [7:0] rate;
  } cst_rate_row_t;
  logic clk_sys;
  logic rst_n;
  logic pkt_valid, pkt_is_primary, pkt_dir, pkt_mode28;
  cst_kind_t pkt_kind;
  logic [6:0] pkt_addr, pkt_speed, step_reg;
  logic [12:0] pkt_fn_mask, pkt_fn_value;
  logic [9:0] pkt_cv_index, cfg_rd_addr;
  logic [7:0] pkt_cv_data, cfg_rd_data_reg, accel_rate_reg, brake_rate_reg, motor_level_reg;
  logic consist_active, dir_reg, light_key_forward, light_key_reverse;
  logic [11:0] fn_state;
  int error_cnt;
  int cmp_count;
  int cycles;
  cst_rate_row_t rows [8];
  logic [9:0] regs [8];

  cst_top u_dut (.clk_sys, .rst_n, .pkt_valid, .pkt_kind, .pkt_is_primary, .pkt_addr, .pkt_dir, .pkt_speed,
    .pkt_mode28, .pkt_fn_mask, .pkt_fn_value, .pkt_cv_index, .pkt_cv_data, .cfg_rd_addr, .cfg_rd_data_reg,
    .consist_active, .dir_reg, .step_reg, .light_key_forward, .light_key_reverse, .fn_state,
    .accel_rate_reg, .brake_rate_reg, .motor_level_reg);
  cst_station u_stn (.clk_sys, .pkt_valid, .pkt_kind, .pkt_is_primary, .pkt_addr, .pkt_dir, .pkt_speed,
    .pkt_mode28, .pkt_fn_mask, .pkt_fn_value, .pkt_cv_index, .pkt_cv_data);

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // The whole run needs well under a thousand cycles.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      $display("[ERR] timeout expected finish seen hang");
      end_sim();
    end
  end

  task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask

  task automatic rd(input logic [9:0] addr, input logic [7:0] exp);
    cfg_rd_addr = addr;
    tick();
    chk("cfg_rd_data_reg", {4'h0, exp}, {4'h0, cfg_rd_data_reg});
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] data);
    u_stn.prog(1'b1, 7'h00, idx, data);
  endtask

  task automatic drive(input logic [6:0] step, input logic dir, input logic m28, input logic [7:0] motor);
    u_stn.spd(1'b1, 7'h00, dir, step, m28);
    chk("step_reg", {5'h0, step}, {5'h0, step_reg});
    tick();
    chk("motor_level_reg", {4'h0, motor}, {4'h0, motor_level_reg});
  endtask

  task automatic keys(input logic [11:0] fns, input logic [1:0] lights);
    chk("fn_state", fns, fn_state);
    chk("light_keys", {10'h0, lights}, {10'h0, light_key_forward, light_key_reverse});
  endtask

  initial begin
    rst_n = 1'b0;
    cfg_rd_addr = 10'h000;
    error_cnt = 0;
    cmp_count = 0;
    cycles = 0;
    rows = '{32'h0a05_030f, 32'h0a85_0305, 32'hfa14_03ff, 32'h038a_0300,
             32'h2880_0328, 32'h287f_0028, 32'h287f_8028, 32'h807f_85ff};
    regs = '{10'h013, 10'h015, 10'h016, 10'h017, 10'h018, 10'h019, 10'h042, 10'h05f};
    repeat (5) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    tick();
    chk("dir_reg", 12'h001, {11'h0, dir_reg});
    chk("consist_active", 12'h000, {11'h0, consist_active});
    rd(10'h042, 8'h80);
    rd(10'h05f, 8'h80);
    foreach (regs[i]) begin
      wr(regs[i], 8'h3c ^ regs[i][7:0]);
      rd(regs[i], 8'h3c ^ regs[i][7:0]);
    end
    wr(10'h3f0, 8'haa);
    rd(10'h3f0, 8'h00);
    foreach (rows[i]) begin
      wr(10'h003, rows[i].base);
      wr(10'h004, rows[i].base);
      wr(10'h017, rows[i].offset);
      wr(10'h018, rows[i].offset);
      wr(10'h013, rows[i].consist);
      tick();
      chk("accel_rate_reg", {4'h0, rows[i].rate}, {4'h0, accel_rate_reg});
      chk("brake_rate_reg", {4'h0, rows[i].rate}, {4'h0, brake_rate_reg});
    end
    // Speed curve: user points at both ends of the table, config left disabled first.
    wr(10'h013, 8'h00);
    wr(10'h01d, 8'h00);
    wr(10'h043, 8'h64);
    wr(10'h05e, 8'hc8);
    wr(10'h019, 8'h10);
    wr(10'h042, 8'h40);
    drive(7'h1c, 1'b1, 1'b1, 8'hff);
    wr(10'h01d, 8'h10);
    drive(7'h1c, 1'b1, 1'b1, 8'h64);
    drive(7'h01, 1'b1, 1'b1, 8'h32);
    wr(10'h042, 8'hc0);
    drive(7'h1c, 1'b1, 1'b1, 8'hff);
    drive(7'h01, 1'b1, 1'b1, 8'h96);
    wr(10'h05f, 8'h40);
    drive(7'h01, 1'b0, 1'b1, 8'h32);
    drive(7'h7e, 1'b0, 1'b0, 8'h64);
    drive(7'h02, 1'b0, 1'b0, 8'h27);
    wr(10'h05f, 8'h80);
    drive(7'h1c, 1'b0, 1'b1, 8'hc8);
    wr(10'h019, 8'h02);
    drive(7'h1c, 1'b0, 1'b1, 8'hff);
    // Reverse-facing consist at address 5.
    wr(10'h013, 8'h85);
    chk("consist_active", 12'h001, {11'h0, consist_active});
    u_stn.spd(1'b0, 7'h05, 1'b1, 7'h14, 1'b1);
    chk("dir_reg", 12'h000, {11'h0, dir_reg});
    u_stn.spd(1'b1, 7'h00, 1'b1, 7'h07, 1'b1);
    u_stn.spd(1'b0, 7'h06, 1'b1, 7'h09, 1'b1);
    chk("step_reg", 12'h014, {5'h0, step_reg});
    chk("dir_reg", 12'h000, {11'h0, dir_reg});
    u_stn.prog(1'b0, 7'h05, 10'h042, 8'h11);
    rd(10'h042, 8'hc0);
    wr(10'h015, 8'h01);
    wr(10'h016, 8'h12);
    u_stn.fn(1'b0, 7'h05, 13'h1fff, 13'h1fff);
    keys(12'h401, 2'b01);
    u_stn.fn(1'b1, 7'h00, 13'h1fff, 13'h1fff);
    keys(12'hfff, 2'b11);
    u_stn.fn(1'b0, 7'h05, 13'h1fff, 13'h0000);
    keys(12'hbfe, 2'b10);
    wr(10'h016, 8'h01);
    u_stn.fn(1'b0, 7'h05, 13'h0801, 13'h0800);
    keys(12'hbfe, 2'b00);
    wr(10'h013, 8'h00);
    chk("consist_active", 12'h000, {11'h0, consist_active});
    u_stn.fn(1'b0, 7'h05, 13'h0002, 13'h0000);
    keys(12'hbfe, 2'b00);
    u_stn.spd(1'b1, 7'h00, 1'b1, 7'h03, 1'b1);
    chk("step_reg", 12'h003, {5'h0, step_reg});
    chk("dir_reg", 12'h001, {11'h0, dir_reg});
    // A second reset in mid-run must bring the stored settings back to their reset values.
    rst_n = 1'b0;
    repeat (2) tick();
    rst_n = 1'b1;
    rd(10'h013, 8'h00);
    rd(10'h042, 8'h80);
    chk("step_reg", 12'h000, {5'h0, step_reg});
    end_sim();
  end
endmodule // testbench
